/* pwrseq_pkg.sv */
// package: constants shared by the display-end and host-end sequencers.
// assumes both ends run on ref_clk_i at 125 MHz and share one uart rate.
//
// Summary of operation
// - host waits 500 ms after reset
// - host ignores receive line while settling
// - host allows 3 s for big cards
// - host sends 0x55 at 9600, awaits 0x06
// - link starts at 9600 bps
// - splash after 5 s without autobaud
// - autobaud in window keeps screen blank
// - autorun script starts with card present
// - host holds reset low over 2 us
// - unknown command answered with 0x15
package pwrseq_pkg;
  // =====================================
  // clock and timing
  // =====================================
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned SETTLE_MS = 500;
  localparam int unsigned SETTLE_CYCLES = SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned CARD_INIT_S = 3;
  localparam int unsigned CARD_INIT_CYCLES = CARD_INIT_S * CLK_HZ;
  localparam int unsigned SPLASH_WAIT_S = 5;
  localparam int unsigned SPLASH_WAIT_CYCLES = SPLASH_WAIT_S * CLK_HZ;
  localparam int unsigned RESET_PULSE_NS = 2000;
  // least time rounds up; one extra cycle for "longer than"
  localparam int unsigned RESET_PULSE_CYCLES =
    (RESET_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000 + 1;
  // =====================================
  // protocol bytes
  // =====================================
  localparam logic [7:0] BYTE_AUTOBAUD = 8'h55;
  localparam logic [7:0] BYTE_ACK = 8'h06;
  localparam logic [7:0] BYTE_NAK = 8'h15;
  localparam int unsigned CNT_W = 32;
endpackage

/* pwrseq_if.sv */
// interface: serial link and reset line between host and display.
// assumes one shared clock; tx/rx named from the display's view.
interface pwrseq_if;
  logic dev_tx; // display to host, idle high
  logic dev_rx; // host to display, idle high
  logic reset_n_o; // host-driven level of the open-drain reset
  logic reset_n_oe; // host pulls the reset line low while high
  logic reset_n; // resolved reset level, pulled up
  assign reset_n = reset_n_oe ? reset_n_o : 1'b1;
  modport device (output dev_tx, input dev_rx, input reset_n);
  modport host (input dev_tx, output dev_rx, output reset_n_o,
    output reset_n_oe, input reset_n);
endinterface

/* pwrseq_device.sv */
// display end: settle, wait for autobaud, splash or stay blank, autorun.
// assumes dev_rx is asynchronous to ref_clk_i; reset line is synchronised.
module pwrseq_device #(
  parameter int unsigned SETTLE_CYC = pwrseq_pkg::SETTLE_CYCLES,
  parameter int unsigned SPLASH_CYC = pwrseq_pkg::SPLASH_WAIT_CYCLES,
  parameter int unsigned CARD_CYC = pwrseq_pkg::CARD_INIT_CYCLES,
  // bit time; short values only make simulation affordable
  parameter int unsigned BIT_CYC = pwrseq_pkg::BIT_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic card_fat_present_i,
  input wire logic autorun_script_file_i,
  pwrseq_if.device link,
  output logic splash_on_o,
  output logic ready_o,
  output logic script_run_o,
  output logic [7:0] cmd_byte_o,
  output logic cmd_valid_o
);
  typedef enum {S_SETTLE, S_CARD, S_WAIT, S_SPLASH, S_RUN} phase_t;
  typedef enum {R_IDLE, R_START, R_DATA, R_STOP} rxs_t;
  typedef struct packed {
    phase_t phase;
    logic [31:0] tmr;
    logic [1:0] rx_sync;
    logic [1:0] rst_sync;
    logic [1:0] card_sync;
    logic [1:0] auto_sync;
    rxs_t rxs;
    logic [15:0] rbit;
    logic [3:0] ridx;
    logic [7:0] rsh;
    logic tx_busy;
    logic [15:0] tbit;
    logic [3:0] tidx;
    logic [9:0] tsh;
    logic tx;
    logic splash;
    logic ready;
    logic script;
    logic [7:0] cmd;
    logic cmd_v;
  } state_t;
  state_t s;
  state_t next_s;
  logic got;
  logic [7:0] got_byte;
  logic [7:0] reply;
  logic send;

  // =====================================
  // next state
  // =====================================
  always_comb begin
    next_s = s;
    got = 1'b0;
    got_byte = s.rsh;
    reply = pwrseq_pkg::BYTE_NAK;
    send = 1'b0;
    next_s.rx_sync = {s.rx_sync[0], link.dev_rx};
    next_s.rst_sync = {s.rst_sync[0], link.reset_n};
    next_s.card_sync = {s.card_sync[0], card_fat_present_i};
    next_s.auto_sync = {s.auto_sync[0], autorun_script_file_i};
    next_s.cmd_v = 1'b0;
    // receiver at fixed default rate
    case (s.rxs)
      R_IDLE: begin
        if (!s.rx_sync[1]) begin
          next_s.rxs = R_START;
          next_s.rbit = 16'(BIT_CYC / 2);
        end
      end
      R_START: begin
        if (s.rbit == 16'h0000) begin
          next_s.rxs = s.rx_sync[1] ? R_IDLE : R_DATA;
          next_s.rbit = 16'(BIT_CYC - 1);
          next_s.ridx = 4'h0;
        end else begin
          next_s.rbit = s.rbit - 16'h0001;
        end
      end
      R_DATA: begin
        if (s.rbit == 16'h0000) begin
          next_s.rsh = {s.rx_sync[1], s.rsh[7:1]};
          next_s.rbit = 16'(BIT_CYC - 1);
          next_s.ridx = s.ridx + 4'h1;
          if (s.ridx == 4'h7) begin
            next_s.rxs = R_STOP;
          end
        end else begin
          next_s.rbit = s.rbit - 16'h0001;
        end
      end
      R_STOP: begin
        if (s.rbit == 16'h0000) begin
          next_s.rxs = R_IDLE;
          got = s.rx_sync[1];
        end else begin
          next_s.rbit = s.rbit - 16'h0001;
        end
      end
      default: next_s.rxs = R_IDLE;
    endcase
    // start-up sequence
    case (s.phase)
      S_SETTLE: begin
        // bytes arriving while settling are dropped
        if (s.tmr >= 32'(SETTLE_CYC - 1)) begin
          next_s.tmr = '0;
          next_s.phase = s.card_sync[1] ? S_CARD : S_WAIT;
        end else begin
          next_s.tmr = s.tmr + 32'h0000_0001;
        end
      end
      S_CARD: begin
        if (s.tmr >= 32'(CARD_CYC - 1)) begin
          next_s.tmr = '0;
          next_s.phase = S_WAIT;
          next_s.ready = 1'b1;
          if (s.auto_sync[1]) begin
            next_s.phase = S_RUN;
            next_s.script = 1'b1;
          end
        end else begin
          next_s.tmr = s.tmr + 32'h0000_0001;
        end
      end
      S_WAIT: begin
        next_s.ready = 1'b1;
        if (got && got_byte == pwrseq_pkg::BYTE_AUTOBAUD) begin
          next_s.phase = S_RUN;
          send = 1'b1;
          reply = pwrseq_pkg::BYTE_ACK;
        end else if (got) begin
          send = 1'b1;
        end else if (s.tmr >= 32'(SPLASH_CYC - 1)) begin
          next_s.phase = S_SPLASH;
          next_s.splash = 1'b1;
        end else begin
          next_s.tmr = s.tmr + 32'h0000_0001;
        end
      end
      S_SPLASH, S_RUN: begin
        if (got && got_byte == pwrseq_pkg::BYTE_AUTOBAUD) begin
          send = 1'b1;
          reply = pwrseq_pkg::BYTE_ACK;
        end else if (got) begin
          next_s.cmd = got_byte;
          next_s.cmd_v = 1'b1;
          send = 1'b1;
        end
      end
      default: next_s.phase = S_SETTLE;
    endcase
    // transmitter; a reply during a busy frame is dropped
    if (s.tx_busy) begin
      if (s.tbit == 16'h0000) begin
        next_s.tbit = 16'(BIT_CYC - 1);
        next_s.tx = s.tsh[0];
        next_s.tsh = {1'b1, s.tsh[9:1]};
        next_s.tidx = s.tidx + 4'h1;
        // stop bit stands a full bit time before the next frame
        if (s.tidx == 4'hA) begin
          next_s.tx_busy = 1'b0;
          next_s.tx = 1'b1;
        end
      end else begin
        next_s.tbit = s.tbit - 16'h0001;
      end
    end else if (send) begin
      next_s.tx_busy = 1'b1;
      next_s.tsh = {1'b1, reply, 1'b0};
      next_s.tbit = 16'h0000;
      next_s.tidx = 4'h0;
    end
    // external reset restarts the sequence
    if (!s.rst_sync[1]) begin
      next_s = '0;
      next_s.rx_sync = 2'b11;
      // keep sampling the line, or the restart never ends
      next_s.rst_sync = {s.rst_sync[0], link.reset_n};
      next_s.card_sync = {s.card_sync[0], card_fat_present_i};
      next_s.auto_sync = {s.auto_sync[0], autorun_script_file_i};
      next_s.tx = 1'b1;
    end
  end

  // =====================================
  // registers
  // =====================================
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.rx_sync <= 2'b11;
      s.rst_sync <= 2'b11;
      s.tx <= 1'b1;
    end else if (clk_en_i) begin
      s <= next_s;
    end
  end

  assign link.dev_tx = s.tx;
  assign splash_on_o = s.splash;
  assign ready_o = s.ready;
  assign script_run_o = s.script;
  assign cmd_byte_o = s.cmd;
  assign cmd_valid_o = s.cmd_v;
endmodule

/* pwrseq_host.sv */
// host end: pulse reset, wait out settling, send autobaud, await ack.
// assumes dev_tx is asynchronous; it is synchronised before use.
module pwrseq_host #(
  parameter int unsigned SETTLE_CYC = pwrseq_pkg::SETTLE_CYCLES,
  parameter int unsigned CARD_CYC = pwrseq_pkg::CARD_INIT_CYCLES,
  // bit time; must match the display end
  parameter int unsigned BIT_CYC = pwrseq_pkg::BIT_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire logic big_card_i,
  pwrseq_if.host link,
  output logic linked_o,
  output logic nak_o,
  output logic busy_o
);
  typedef enum {H_IDLE, H_RST, H_SETTLE, H_SEND, H_WAIT} hph_t;
  typedef struct packed {
    hph_t ph;
    logic [31:0] tmr;
    logic [1:0] rx_sync;
    logic rx_on;
    logic [15:0] rbit;
    logic [3:0] ridx;
    logic [7:0] rsh;
    logic [15:0] tbit;
    logic [3:0] tidx;
    logic [9:0] tsh;
    logic tx;
    logic rst_oe;
    logic linked;
    logic nak;
    logic busy;
  } hstate_t;
  hstate_t s;
  hstate_t next_s;
  logic [31:0] wait_cyc;

  // =====================================
  // next state
  // =====================================
  always_comb begin
    next_s = s;
    next_s.rx_sync = {s.rx_sync[0], link.dev_tx};
    wait_cyc = big_card_i ? 32'(SETTLE_CYC + CARD_CYC) : 32'(SETTLE_CYC);
    case (s.ph)
      H_IDLE: begin
        if (start_i) begin
          next_s.ph = H_RST;
          next_s.rst_oe = 1'b1;
          next_s.tmr = '0;
          next_s.linked = 1'b0;
          next_s.nak = 1'b0;
        end
      end
      H_RST: begin
        if (s.tmr >= 32'(pwrseq_pkg::RESET_PULSE_CYCLES - 1)) begin
          next_s.rst_oe = 1'b0;
          next_s.ph = H_SETTLE;
          next_s.tmr = '0;
        end else begin
          next_s.tmr = s.tmr + 32'h0000_0001;
        end
      end
      H_SETTLE: begin
        // receiver held off
        if (s.tmr >= wait_cyc - 32'h0000_0001) begin
          next_s.ph = H_SEND;
          next_s.tsh = {1'b1, pwrseq_pkg::BYTE_AUTOBAUD, 1'b0};
          next_s.tbit = 16'(BIT_CYC - 1);
          next_s.tidx = 4'h0;
          next_s.tx = 1'b0;
        end else begin
          next_s.tmr = s.tmr + 32'h0000_0001;
        end
      end
      H_SEND: begin
        if (s.tbit == 16'h0000) begin
          next_s.tbit = 16'(BIT_CYC - 1);
          next_s.tsh = {1'b1, s.tsh[9:1]};
          next_s.tx = s.tsh[1];
          next_s.tidx = s.tidx + 4'h1;
          // listen from the stop bit on: the reply starts mid-stop
          if (s.tidx == 4'h8) begin
            next_s.ph = H_WAIT;
            next_s.tx = 1'b1;
            next_s.rx_on = 1'b0;
          end
        end else begin
          next_s.tbit = s.tbit - 16'h0001;
        end
      end
      H_WAIT: begin
        if (!s.rx_on) begin
          if (!s.rx_sync[1]) begin
            next_s.rx_on = 1'b1;
            next_s.rbit = 16'(BIT_CYC + BIT_CYC / 2);
            next_s.ridx = 4'h0;
          end
        end else if (s.rbit == 16'h0000) begin
          next_s.rbit = 16'(BIT_CYC - 1);
          next_s.ridx = s.ridx + 4'h1;
          if (s.ridx == 4'h8) begin
            next_s.rx_on = 1'b0;
            next_s.ph = H_IDLE;
            next_s.linked = (s.rsh == pwrseq_pkg::BYTE_ACK);
            next_s.nak = (s.rsh != pwrseq_pkg::BYTE_ACK);
          end else begin
            next_s.rsh = {s.rx_sync[1], s.rsh[7:1]};
          end
        end else begin
          next_s.rbit = s.rbit - 16'h0001;
        end
      end
      default: next_s.ph = H_IDLE;
    endcase
    next_s.busy = (next_s.ph != H_IDLE);
  end

  // =====================================
  // registers
  // =====================================
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.rx_sync <= 2'b11;
      s.tx <= 1'b1;
    end else if (clk_en_i) begin
      s <= next_s;
    end
  end

  assign link.dev_rx = s.tx;
  assign link.reset_n_o = 1'b0;
  assign link.reset_n_oe = s.rst_oe;
  assign linked_o = s.linked;
  assign nak_o = s.nak;
  assign busy_o = s.busy;
endmodule

/* pwrseq_chk.sv */
// checker: timing relations on the host-display power-up link.
// assumes one clock domain; the bench instantiates it beside the interface.
module pwrseq_chk #(
  parameter int unsigned SETTLE_CYC = 200,
  parameter int unsigned SPLASH_CYC = 2000
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic dev_tx,
  input wire logic dev_rx,
  input wire logic reset_n_oe,
  input wire logic reset_n,
  input wire logic splash_on_o,
  input wire logic ready_o,
  input wire logic script_run_o,
  input wire logic linked_o,
  input wire logic nak_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  int unsigned oe_cnt;
  int unsigned up_cnt;
  int unsigned rdy_cnt;
  // =====================================
  // helper counters
  // =====================================
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oe_cnt <= 0;
      up_cnt <= 0;
      rdy_cnt <= 0;
    end else begin
      oe_cnt <= reset_n_oe ? oe_cnt + 1 : 0;
      up_cnt <= !reset_n ? 0 : up_cnt + 1;
      rdy_cnt <= (ready_o && !splash_on_o) ? rdy_cnt + 1 : 0;
    end
  end
  // =====================================
  // assertions
  // =====================================
  reset_idle_a: assert property (disable iff (1'b0)
    !resetn_i |-> dev_tx && dev_rx && !reset_n_oe)
    else $error("link not idle in reset");
  reset_pulse_a: assert property ($fell(reset_n_oe) |-> oe_cnt > 250)
    else $error("reset pulse too short");
  settle_quiet_a: assert property ($fell(dev_rx) |->
    up_cnt >= SETTLE_CYC - 1)
    else $error("host spoke while settling");
  splash_window_a: assert property ($rose(splash_on_o) |->
    rdy_cnt >= SPLASH_CYC - 1 && rdy_cnt <= SPLASH_CYC + 1)
    else $error("splash window length wrong");
  splash_sticky_a: assert property (splash_on_o |=> splash_on_o)
    else $error("splash dropped");
  script_no_splash_a: assert property (script_run_o |-> !splash_on_o)
    else $error("splash during autorun");
  ack_blank_a: assert property (linked_o |-> !splash_on_o)
    else $error("splash after autobaud");
  link_excl_a: assert property (!(linked_o && nak_o))
    else $error("ack and nak together");
endmodule

/* powerup_autobaud_sequencer_bench.sv */
// bench: host and display ends joined, autorun, autobaud and splash runs.
// assumes a shortened bit time, so a serial frame costs ~640 cycles.
module powerup_autobaud_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 200;
  localparam int SP = 2000;
  localparam int CD = 300;
  // short bit time keeps the run far below the cycle budget
  localparam int BT = 64;
  logic ref_clk_i = 0, resetn_i = 1, clk_en_i = 1, start_i = 0;
  logic card = 0, autorun = 0, big = 0;
  logic splash_on_o, ready_o, script_run_o, cmd_valid_o;
  logic linked_o, nak_o, busy_o;
  logic [7:0] cmd_byte_o, b;
  logic [15:0] lfsr = 16'h50d0;
  int errors = 0, n_compared = 0;
  pwrseq_if link_if ();
  pwrseq_device #(.SETTLE_CYC(ST), .SPLASH_CYC(SP), .CARD_CYC(CD),
    .BIT_CYC(BT))
    pwrseq_device_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .clk_en_i(clk_en_i), .card_fat_present_i(card),
    .autorun_script_file_i(autorun), .link(link_if.device),
    .splash_on_o(splash_on_o), .ready_o(ready_o),
    .script_run_o(script_run_o), .cmd_byte_o(cmd_byte_o),
    .cmd_valid_o(cmd_valid_o));
  pwrseq_host #(.SETTLE_CYC(ST), .CARD_CYC(CD), .BIT_CYC(BT))
    pwrseq_host_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
    .start_i(start_i), .big_card_i(big), .link(link_if.host),
    .linked_o(linked_o), .nak_o(nak_o), .busy_o(busy_o));
  pwrseq_chk #(.SETTLE_CYC(ST), .SPLASH_CYC(SP)) pwrseq_chk_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .dev_tx(link_if.dev_tx),
    .dev_rx(link_if.dev_rx), .reset_n_oe(link_if.reset_n_oe),
    .reset_n(link_if.reset_n), .splash_on_o(splash_on_o),
    .ready_o(ready_o), .script_run_o(script_run_o),
    .linked_o(linked_o), .nak_o(nak_o));
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // =====================================
  // helpers
  // =====================================
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic exp_splash(input logic ab, input logic c,
      input logic a);
    return !ab && !(c && a);
  endfunction
  task automatic final_report();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] e,
      input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return script_run_o;
      1: return linked_o;
      2: return splash_on_o;
      3: return !link_if.dev_rx;
      default: return !link_if.dev_tx;
    endcase
  endfunction
  task automatic wait_for(input int s, input int lim);
    int i;
    for (i = 0; i < lim && pick(s) !== 1'b1; i++) @(posedge ref_clk_i);
    if (i >= lim) begin
      errors++;
      $display("Error wait %0d expected 1 seen timeout", s);
      final_report();
    end
  endtask
  // one 8N1 frame, sampled mid-bit, lsb first
  task automatic capture(input int s, output logic [7:0] v);
    wait_for(s, 300000);
    repeat (BT / 2) @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge ref_clk_i);
      v[i] = !pick(s);
    end
    repeat (BT) @(posedge ref_clk_i);
    check("stop bit", 8'h01, {7'h00, !pick(s)});
  endtask
  // =====================================
  // main sequence
  // =====================================
  initial begin
    // a real falling edge, so reset holds from time zero
    resetn_i <= 0;
    card <= 1;
    autorun <= 1;
    repeat (16) @(posedge ref_clk_i);
    resetn_i <= 1;
    repeat (ST + CD - 20) @(posedge ref_clk_i);
    check("early script", 8'h00, script_run_o);
    wait_for(0, 100);
    check("script", 8'h01, script_run_o);
    // host-driven restart, autobaud inside the window
    // big card: host waits settle plus card time
    card <= 1;
    big <= 1;
    autorun <= 0;
    lfsr = lfsr_next(lfsr);
    repeat (lfsr[5:0] + 1) @(posedge ref_clk_i);
    start_i <= 1;
    @(posedge ref_clk_i);
    start_i <= 0;
    capture(3, b);
    check("autobaud byte", pwrseq_pkg::BYTE_AUTOBAUD, b);
    capture(4, b);
    check("reply byte", pwrseq_pkg::BYTE_ACK, b);
    wait_for(1, 2000);
    check("nak", 8'h00, nak_o);
    check("splash", exp_splash(1, 1, 0), splash_on_o);
    check("script off", 8'h00, script_run_o);
    check("ready", 8'h01, ready_o);
    check("busy", 8'h00, busy_o);
    check("cmd valid", 8'h00, cmd_valid_o);
    check("cmd byte", 8'h00, cmd_byte_o);
    // second reset in mid-run, no host: window runs out
    lfsr = lfsr_next(lfsr);
    @(posedge ref_clk_i);
    resetn_i <= 0;
    card <= lfsr[0];
    autorun <= 0;
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1;
    // a 30-cycle freeze while settling must push the splash back
    repeat (4) @(posedge ref_clk_i);
    clk_en_i <= 0;
    repeat (30) @(posedge ref_clk_i);
    clk_en_i <= 1;
    repeat (ST + SP - 20) @(posedge ref_clk_i);
    check("early splash", 8'h00, splash_on_o);
    wait_for(2, CD + 200);
    check("splash", exp_splash(0, card, 0), splash_on_o);
    check("ready", 8'h01, ready_o);
    final_report();
  end
endmodule
